/* File: logic/toc_timer.sv */
// toc_timer: module-wide status/control of a 16-bit timer: overflow flag,
// counting mode, clock source, prescaler, counter and channel pin handoff.
// assumes per-channel capture/compare logic outside, fed by chanCenterPwm
// and overflowPulse, and a gpio port block supplying gpioData/gpioDir.
//
// Functional notes
// - up mode: flag sets on wrap to zero
// - center mode: flag sets stepping down from top
// - flag clears by read-while-set then zero write
// - overflow during sequence restarts clear sequence
// - reset clears flag; writing one ignored
// - interrupt when enable and flag both set
// - center select chooses up or up/down count
// - center select forces all channels center PWM
// - source field: none, bus, fixed, external
// - fixed and external clocks synchronised first
// - prescale divides by two to field power
// - prescaler sits after source selection
// - these settings shared by all channels
// - timer-owned pin ignores port data/direction
// - no pin function returns pin to gpio
// - modulo zero or all-ones runs free
// - at top: restart zero, or count down
`timescale 1ns/10ps
module toc_timer
  import toc_pkg::*;
(
  input  wire logic                 mclk,          // bus rate clock, 20 MHz
  input  wire logic                 resetn,        // sync reset, active low
  input  wire toc_bus_t             bus,           // register port request
  output toc_data_t                 rdata,         // read data, next cycle
  input  wire logic                 fixedClkIn,    // fixed system clock
  input  wire logic                 extClkIn,      // external count clock pin
  output logic                      irq,           // level interrupt
  output logic                      overflowPulse, // one cycle per overflow
  output logic                      countDown,     // counter direction
  output logic [15:0]               count,         // counter value
  input  wire toc_chan_cfg_t [CH_NUM-1:0] chanCfg, // per-channel mode bits
  input  wire logic [CH_NUM-1:0]    chanPinOut,    // channel drive value
  input  wire logic [CH_NUM-1:0]    gpioData,      // port data value
  input  wire logic [CH_NUM-1:0]    gpioDir,       // port direction, 1 = out
  output logic [CH_NUM-1:0]         chanCenterPwm, // channel in center PWM
  output logic [CH_NUM-1:0]         chanPinOwned,  // timer owns the pin
  output toc_pin_t [CH_NUM-1:0]     pin            // pin drive, oeN low=drive
);

  //////////////////////////////////////////////////////////////////////////
  // control state

  logic                 tof_r;
  logic                 overflow_irq_enable_r;
  logic                 center_align_select_r;
  logic [1:0]           clks_r;
  logic [2:0]           ps_r;
  logic [15:0]          mod_r;
  logic [15:0]          cnt_r;
  logic                 down_r;
  logic [6:0]           pre_r;
  logic [EV_W-1:0]      evStat_r;
  logic [EV_W-1:0]      evMask_r;
  toc_clr_state_t       clr_r;
  logic [1:0]           syncClk;
  logic [1:0]           syncPrev_r;
  logic                 srcTick;
  logic                 cntTick;
  logic [6:0]           preMask;
  logic [15:0]          topVal;
  logic                 atTop;
  logic                 ovfEvent;
  logic                 bottomEvent;
  logic                 scWr;
  logic                 scRd;
  toc_data_t            scVal;

  assign scWr = bus.wr && (bus.addr == OFS_SC);
  assign scRd = bus.rd && (bus.addr == OFS_SC);

  //////////////////////////////////////////////////////////////////////////
  // clock source selection and prescaler

  // only slow pin clocks pass; a 2-flop synchroniser bounds them to mclk/2
  toc_sync #(
    .W       (2)
  ) u_sync (
    .mclk    (mclk),
    .resetn  (resetn),
    .asyncIn ({extClkIn, fixedClkIn}),
    .syncOut (syncClk)
  );

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      syncPrev_r <= 2'h0;
    end else begin
      syncPrev_r <= syncClk;
    end
  end

  always_comb begin
    case (clks_r)
      CLKS_BUS:   srcTick = 1'b1;
      CLKS_FIXED: srcTick = syncClk[0] && !syncPrev_r[0];
      CLKS_EXT:   srcTick = syncClk[1] && !syncPrev_r[1];
      default:    srcTick = 1'b0;
    endcase
  end

  // divisor tap follows the source mux, so any source is divided alike
  assign preMask = 7'((8'h01 << ps_r) - 8'h01);
  assign cntTick = srcTick && ((pre_r & preMask) == preMask);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pre_r <= PRE_RST;
    end else if (srcTick) begin
      pre_r <= 7'(pre_r + 7'h01);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // counter

  assign topVal = ((mod_r == MOD_RST) || (mod_r == CNT_FULL)) ?
                  CNT_FULL : mod_r;
  assign atTop  = (cnt_r == topVal);

  always_comb begin
    ovfEvent    = 1'b0;
    bottomEvent = 1'b0;
    if (cntTick && atTop && !(center_align_select_r && down_r)) begin
      ovfEvent = 1'b1;
    end
    if (cntTick && center_align_select_r && down_r && (cnt_r == CNT_RST)) begin
      bottomEvent = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_r  <= CNT_RST;
      down_r <= 1'b0;
    end else if (bus.wr && ((bus.addr == OFS_CNTH) ||
                            (bus.addr == OFS_CNTL))) begin
      cnt_r  <= CNT_RST;
      down_r <= 1'b0;
    end else if (cntTick) begin
      if (!center_align_select_r) begin
        down_r <= 1'b0;
        cnt_r  <= atTop ? CNT_RST : 16'(cnt_r + 16'h0001);
      end else if (down_r) begin
        if (cnt_r == CNT_RST) begin
          down_r <= 1'b0;
          cnt_r  <= 16'h0001;
        end else begin
          cnt_r  <= 16'(cnt_r - 16'h0001);
        end
      end else if (atTop) begin
        down_r <= 1'b1;
        cnt_r  <= 16'(cnt_r - 16'h0001);
      end else begin
        cnt_r  <= 16'(cnt_r + 16'h0001);
      end
    end
  end

  assign count         = cnt_r;
  assign countDown     = down_r;
  assign overflowPulse = ovfEvent;

  //////////////////////////////////////////////////////////////////////////
  // status and control register

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      overflow_irq_enable_r  <= SC_RST[SC_OVERFLOW_IRQ_ENABLE_BIT];
      center_align_select_r <= SC_RST[SC_CENTER_ALIGN_SELECT_BIT];
      clks_r  <= SC_RST[SC_CLKS_HI:SC_CLKS_LO];
      ps_r    <= SC_RST[SC_PS_HI:SC_PS_LO];
    end else if (scWr) begin
      overflow_irq_enable_r  <= bus.wdata[SC_OVERFLOW_IRQ_ENABLE_BIT];
      center_align_select_r <= bus.wdata[SC_CENTER_ALIGN_SELECT_BIT];
      clks_r  <= bus.wdata[SC_CLKS_HI:SC_CLKS_LO];
      ps_r    <= bus.wdata[SC_PS_HI:SC_PS_LO];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mod_r <= MOD_RST;
    end else if (bus.wr && (bus.addr == OFS_MODH)) begin
      mod_r[15:8] <= bus.wdata;
    end else if (bus.wr && (bus.addr == OFS_MODL)) begin
      mod_r[7:0] <= bus.wdata;
    end
  end

  // clear sequence: arm on a read that sees the flag, fire on a zero write
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      clr_r <= CLR_IDLE;
    end else begin
      case (clr_r)
        CLR_IDLE: begin
          if (scRd && tof_r && !ovfEvent) begin
            clr_r <= CLR_ARMED;
          end
        end
        CLR_ARMED: begin
          if (ovfEvent || scWr) begin
            clr_r <= CLR_IDLE;
          end
        end
        default: clr_r <= CLR_IDLE;
      endcase
    end
  end

  // a fresh overflow always wins over the clearing write
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tof_r <= SC_RST[SC_TOF_BIT];
    end else if (ovfEvent) begin
      tof_r <= 1'b1;
    end else if (scWr && (clr_r == CLR_ARMED) &&
                 !bus.wdata[SC_TOF_BIT]) begin
      tof_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // event status, mask and interrupt

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      evStat_r <= EV_RST;
    end else begin
      evStat_r <= (evStat_r &
                   ~((bus.wr && (bus.addr == OFS_EVSTAT)) ?
                     bus.wdata[EV_W-1:0] : EV_RST)) |
                  {bottomEvent, ovfEvent};
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      evMask_r <= EV_RST;
    end else if (bus.wr && (bus.addr == OFS_EVMASK)) begin
      evMask_r <= bus.wdata[EV_W-1:0];
    end
  end

  assign irq = (tof_r && overflow_irq_enable_r) || (|(evStat_r & evMask_r));

  //////////////////////////////////////////////////////////////////////////
  // read port

  assign scVal = {tof_r, overflow_irq_enable_r, center_align_select_r, clks_r, ps_r};

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        OFS_SC:     rdata <= scVal;
        OFS_CNTH:   rdata <= cnt_r[15:8];
        OFS_CNTL:   rdata <= cnt_r[7:0];
        OFS_MODH:   rdata <= mod_r[15:8];
        OFS_MODL:   rdata <= mod_r[7:0];
        OFS_EVSTAT: rdata <= {{(8-EV_W){1'b0}}, evStat_r};
        OFS_EVMASK: rdata <= {{(8-EV_W){1'b0}}, evMask_r};
        default:    rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // channel mode and pin handoff

  genvar ch;
  generate
    for (ch = 0; ch < CH_NUM; ch++) begin : g_chan
      logic owned;
      logic drives;

      assign owned  = (chanCfg[ch].edgeLevel != ELS_NO_PIN);
      // capture mode only listens unless center select is set; compare and PWM drive the pin
      assign drives = center_align_select_r || (chanCfg[ch].modeSel != MS_CAPTURE);

      assign chanCenterPwm[ch] = center_align_select_r;
      assign chanPinOwned[ch]  = owned;

      always_ff @(posedge mclk) begin
        if (!resetn) begin
          pin[ch].out <= 1'b0;
          pin[ch].oeN <= 1'b1;
        end else if (owned) begin
          pin[ch].out <= drives ? chanPinOut[ch] : 1'b0;
          pin[ch].oeN <= !drives;
        end else begin
          pin[ch].out <= gpioData[ch];
          pin[ch].oeN <= !gpioDir[ch];
        end
      end
    end
  endgenerate

endmodule

/* File: common/toc_pkg.sv */
// toc_pkg: constants, field layout and carrier types of the timer
// overflow / clock control block.
// assumes an 8-bit register port with a 3-bit word address.
package toc_pkg;

  localparam int CH_NUM = 1;             // channels sharing this control

  typedef logic [2:0] toc_addr_t;
  typedef logic [7:0] toc_data_t;

  // register offsets (word index on the register port)
  localparam toc_addr_t OFS_SC     = 3'h0;
  localparam toc_addr_t OFS_CNTH   = 3'h1;
  localparam toc_addr_t OFS_CNTL   = 3'h2;
  localparam toc_addr_t OFS_MODH   = 3'h3;
  localparam toc_addr_t OFS_MODL   = 3'h4;
  localparam toc_addr_t OFS_EVSTAT = 3'h5;
  localparam toc_addr_t OFS_EVMASK = 3'h6;

  // status and control field positions
  localparam int SC_TOF_BIT   = 7;
  localparam int SC_OVERFLOW_IRQ_ENABLE_BIT  = 6;
  localparam int SC_CENTER_ALIGN_SELECT_BIT = 5;
  localparam int SC_CLKS_HI   = 4;
  localparam int SC_CLKS_LO   = 3;
  localparam int SC_PS_HI     = 2;
  localparam int SC_PS_LO     = 0;

  // event status / mask bit positions
  localparam int EV_OVF_BIT    = 0;
  localparam int EV_BOTTOM_BIT = 1;
  localparam int EV_W          = 2;

  // clock source encodings
  localparam logic [1:0] CLKS_NONE  = 2'h0;
  localparam logic [1:0] CLKS_BUS   = 2'h1;
  localparam logic [1:0] CLKS_FIXED = 2'h2;
  localparam logic [1:0] CLKS_EXT   = 2'h3;

  // channel pin-function encoding that releases the pin, and capture mode encoding
  localparam logic [1:0] ELS_NO_PIN = 2'h0;
  localparam logic [1:0] MS_CAPTURE = 2'h0;

  // reset values
  localparam toc_data_t    SC_RST     = 8'h00;
  localparam logic [15:0]  CNT_RST    = 16'h0000;
  localparam logic [15:0]  MOD_RST    = 16'h0000;
  localparam logic [15:0]  CNT_FULL   = 16'hFFFF;
  localparam logic [EV_W-1:0] EV_RST  = 2'h0;
  localparam logic [6:0]   PRE_RST    = 7'h00;

  typedef enum logic {
    CLR_IDLE,
    CLR_ARMED
  } toc_clr_state_t;

  typedef struct packed {
    logic      wr;
    logic      rd;
    toc_addr_t addr;
    toc_data_t wdata;
  } toc_bus_t;

  typedef struct packed {
    logic [1:0] modeSel;
    logic [1:0] edgeLevel;
  } toc_chan_cfg_t;

  typedef struct packed {
    logic out;
    logic oeN;
  } toc_pin_t;

endpackage

/* File: logic/toc_sync.sv */
// toc_sync: two-flop level synchroniser, one lane per bit.
// assumes inputs are asynchronous to mclk and slower than mclk/2.
`timescale 1ns/10ps
module toc_sync #(
  parameter int W = 2
) (
  input  wire logic         mclk,    // bus rate clock
  input  wire logic         resetn,  // synchronous reset, active low
  input  wire logic [W-1:0] asyncIn, // raw pin levels
  output logic      [W-1:0] syncOut  // levels in mclk domain
);

  logic [W-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          meta_r[i]  <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          meta_r[i]  <= asyncIn[i];
          syncOut[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule

/* File: bench/toc_timer_properties.sv */
// toc_timer_properties: port-level checks of toc_timer.
// assumes CH_NUM of 1 and a bind onto every toc_timer.
`timescale 1ns/10ps
module toc_timer_properties
  import toc_pkg::*;
(
  input wire logic                   mclk,          // clock
  input wire logic                   resetn,        // sync reset
  input wire toc_bus_t               bus,           // register port
  input wire logic                   irq,           // interrupt
  input wire logic                   overflowPulse, // overflow event
  input wire logic                   countDown,     // direction
  input wire logic [15:0]            count,         // counter
  input wire toc_chan_cfg_t [CH_NUM-1:0] chanCfg,   // channel mode
  input wire logic [CH_NUM-1:0]      chanPinOut,    // channel drive
  input wire logic [CH_NUM-1:0]      gpioData,      // port data
  input wire logic [CH_NUM-1:0]      gpioDir,       // port direction
  input wire logic [CH_NUM-1:0]      chanCenterPwm, // center pwm
  input wire logic [CH_NUM-1:0]      chanPinOwned,  // pin owned
  input wire toc_pin_t [CH_NUM-1:0]  pin            // pin drive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  // bus writes excluded: a counter write restarts the count
  a_up_wrap: assert property (overflowPulse && !chanCenterPwm[0]
    && !bus.wr |=> count == 16'h0000) else $error("no wrap to zero");
  a_ctr_down: assert property (overflowPulse && chanCenterPwm[0]
    && !bus.wr |=> countDown && count == $past(count) - 16'h1)
    else $error("no down step after center overflow");
  a_ovf_rising: assert property (overflowPulse && chanCenterPwm[0]
    |-> !countDown) else $error("center overflow while counting down");
  a_up_step: assert property (!chanCenterPwm[0] && !countDown
    && !bus.wr ##1 $changed(count)
    |-> count == $past(count) + 16'h1 || count == 16'h0000)
    else $error("up count step wrong");
  a_center_chan: assert property (bus.wr && bus.addr == OFS_SC
    |=> chanCenterPwm[0] == $past(bus.wdata[SC_CENTER_ALIGN_SELECT_BIT]))
    else $error("center pwm select not followed");
  a_owned_map: assert property (chanPinOwned[0] ==
    (chanCfg[0].edgeLevel != ELS_NO_PIN)) else $error("pin owner wrong");
  // resetn in the antecedent: the release edge still shows reset pin values
  a_pin_gpio: assert property (resetn && !chanPinOwned[0] |=>
    pin[0].out == $past(gpioData[0]) && pin[0].oeN == !$past(gpioDir[0]))
    else $error("released pin not from port");
  a_pin_timer: assert property (resetn && chanPinOwned[0] &&
    (chanCenterPwm[0]
    || chanCfg[0].modeSel != 2'h0) |=> !pin[0].oeN
    && pin[0].out == $past(chanPinOut[0])) else $error("timer pin wrong");
  c_center_ovf: cover property (overflowPulse && chanCenterPwm[0]);
  c_irq: cover property (irq);
  c_pin_drive: cover property (chanPinOwned[0] && !pin[0].oeN);
endmodule

bind toc_timer toc_timer_properties u_props (.mclk, .resetn, .bus, .irq,
  .overflowPulse, .countDown, .count, .chanCfg, .chanPinOut, .gpioData,
  .gpioDir, .chanCenterPwm, .chanPinOwned, .pin);

/* File: bench/toc_timer_bench.sv */
// toc_timer_bench: register-level tests of toc_timer.
// assumes the checker is bound from its own file.
`timescale 1ns/10ps
module toc_timer_bench
  import toc_pkg::*;
;
  logic                  mclk, resetn, fixedClkIn, extClkIn;
  logic                  irq, overflowPulse, countDown;
  toc_bus_t              bus;
  toc_data_t             rdata;
  logic [15:0]           count;
  toc_chan_cfg_t [CH_NUM-1:0] chanCfg;
  logic [CH_NUM-1:0]     chanPinOut, gpioData, gpioDir;
  logic [CH_NUM-1:0]     chanCenterPwm, chanPinOwned;
  toc_pin_t [CH_NUM-1:0] pin;
  int                    miscompares, checkCount, n, ph;

  toc_timer dut (.mclk, .resetn, .bus, .rdata, .fixedClkIn, .extClkIn,
    .irq, .overflowPulse, .countDown, .count, .chanCfg, .chanPinOut,
    .gpioData, .gpioDir, .chanCenterPwm, .chanPinOwned, .pin);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // pin clocks well under a quarter of mclk: rise every 8 and 12 cycles
  always @(posedge mclk) begin
    ph <= ph + 1;
    if (ph % 4 == 3) fixedClkIn <= ~fixedClkIn;
    if (ph % 6 == 5) extClkIn <= ~extClkIn;
  end
  ////////////////////////////////////////
  task automatic ck(string nm, logic [31:0] e, logic [31:0] v);
    checkCount++;
    if (v !== e) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, v);
    end
  endtask
  task automatic wr(toc_addr_t a, toc_data_t d);
    @(posedge mclk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    bus <= '0;
  endtask
  task automatic rd(toc_addr_t a, toc_data_t e);
    @(posedge mclk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    bus <= '0;
    @(negedge mclk);
    ck("rdata", e, rdata);
  endtask
  // edges until the next overflow cycle has passed
  task automatic gap(output int k);
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (!overflowPulse && k < 70000);
  endtask
  // first gap only resynchronises to the prescaler phase
  task automatic per(int e);
    gap(n);
    gap(n);
    ck("period", e, n);
  endtask
  task automatic pins(logic [3:0] c, logic [1:0] e);
    @(posedge mclk);
    chanCfg[0] <= c;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    ck("pin", e, pin[0]);
  endtask
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #(50 * 100000);
    miscompares++;
    reportAndStop;
  end
  initial begin
    bus = '0; resetn = 1'b0; fixedClkIn = 1'b0; extClkIn = 1'b0; ph = 0;
    chanCfg = '0; chanPinOut = '0; gpioData = '1; gpioDir = '1;
    miscompares = 0; checkCount = 0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd(OFS_SC, SC_RST);
    rd(3'h7, 8'h00);
    wr(OFS_MODL, 8'h03);
    wr(OFS_SC, 8'h08);
    per(4);
    rd(OFS_SC, 8'h88);
    ck("irq", 0, irq);
    wr(OFS_SC, 8'hC0);
    @(negedge mclk);
    ck("irq", 1, irq);
    n = count;
    repeat (20) @(posedge mclk);
    ck("count", n, count);
    wr(OFS_SC, 8'h40);
    rd(OFS_SC, 8'hC0);
    wr(OFS_SC, 8'h40);
    rd(OFS_SC, 8'h40);
    ck("irq", 0, irq);
    wr(OFS_SC, 8'h48);
    gap(n);
    rd(OFS_SC, 8'hC8);
    gap(n);
    wr(OFS_SC, 8'h48);
    rd(OFS_SC, 8'hC8);
    for (int p = 0; p < 8; p++) begin
      wr(OFS_SC, 8'h08 | p[7:0]);
      per(4 << p);
    end
    wr(OFS_SC, 8'h11);
    per(64);
    wr(OFS_SC, 8'h18);
    per(48);
    wr(OFS_SC, 8'h28);
    @(negedge mclk);
    ck("chanCenterPwm", 1, chanCenterPwm);
    per(6);
    pins(4'h1, 2'b00);
    wr(OFS_SC, 8'h08);
    pins(4'h0, 2'b10);
    pins(4'h9, 2'b00);
    wr(OFS_MODL, 8'h00);
    wr(OFS_CNTL, 8'h00);
    gap(n);
    ck("free period", 65536, n);
    // both event kinds were seen; next overflow is 65536 cycles away
    rd(OFS_EVSTAT, 8'h03);
    wr(OFS_EVSTAT, 8'h03);
    rd(OFS_EVSTAT, 8'h00);
    wr(OFS_EVMASK, 8'h02);
    rd(OFS_EVMASK, 8'h02);
    ck("irq", 0, irq);
    reportAndStop;
  end
endmodule
